// *** include/dio_pkg.sv ***
// Purpose: constants and types shared by the double-data-rate pin cell
// Assumes: APB register window, one 32-bit word per register
// Notes:   offsets are byte addresses
package dio_pkg;
    localparam int          DIO_ADDR_W        = 8;
    localparam int          DIO_DATA_W        = 32;

    localparam logic [7:0]  DIO_CTRL_OFS      = 8'h00;
    localparam logic [7:0]  DIO_STAT_OFS      = 8'h04;

    // control register fields
    localparam int          DIO_CTRL_MODE_LSB = 0;
    localparam int          DIO_CTRL_TRI_LOW  = 2;
    localparam int          DIO_CTRL_OCE_USE  = 3;
    localparam int          DIO_CTRL_NO_DQS   = 4;
    localparam int          DIO_CTRL_SCLR     = 5;

    // status register fields
    localparam int          DIO_STAT_RX_LO    = 0;
    localparam int          DIO_STAT_RX_HI    = 1;
    localparam int          DIO_STAT_RX_VALID = 2;
    localparam int          DIO_STAT_DRIVE    = 3;
    localparam int          DIO_STAT_MODE_LSB = 4;

    typedef enum logic [1:0] {
        DIO_MODE_IN,
        DIO_MODE_OUT,
        DIO_MODE_BIDIR
    } dio_mode_t;

    // reset values of the control fields
    localparam logic [1:0]  DIO_MODE_RST      = 2'h2;
    localparam logic        DIO_TRI_LOW_RST   = 1'h0;
    localparam logic        DIO_OCE_USE_RST   = 1'h0;
    localparam logic        DIO_NO_DQS_RST    = 1'h0;
    localparam logic        DIO_SCLR_RST      = 1'h0;
endpackage

// *** logic/dio_io_cell.sv ***
// Purpose: one double-data-rate io_cell: DDR capture, DDR launch, negedge OE
// Assumes: pclk is the I/O clock; both of its edges are used
// Notes:   pin output is muxed by the clock level itself, so it toggles at 2x
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - DDR input uses one rising-edge and one falling-edge capture register.
// - a latch holds the high-phase bit so both bits align to one edge.
// - two output registers load two core data paths on the rising edge.
// - the clock level selects between the two output registers onto the pin.
// - clock high drives the first bit, clock low drives the second bit.
// - bidirectional mode uses capture and launch paths on the same pin.
// - bidirectional OE register is clocked on the falling edge.
// - output clock enable defaults asserted; output registers then load each rising edge.
// - output clock enable low makes output registers keep their contents.
// - tristate control is active high by default, configurable active low.
// - in strobe-less mode the read strobe is ignored; capture uses the clock.
// - registers take async clear or preset per cell, sync reset, power-up level.
module dio_io_cell
    import dio_pkg::*;
#(
    parameter logic PWR_UP_HIGH = 1'h0
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [DIO_ADDR_W-1:0] paddr,
    input  wire logic [DIO_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [DIO_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  tx_hi,
    input  wire logic                  tx_lo,
    input  wire logic                  ce_out,
    input  wire logic                  oe_req,
    input  wire logic                  sclr,
    output logic                       rx_hi,
    output logic                       rx_lo,
    output logic                       rx_valid,
    input  wire logic                  dq_i,
    output logic                       dq_o,
    output logic                       dq_oe_n,
    input  wire logic                  dqs_i
);

    typedef struct packed {
        logic [1:0]            mode;
        logic                  tri_low;
        logic                  oce_use;
        logic                  no_dqs;
        logic                  sclr_bit;
        logic [DIO_DATA_W-1:0] prdata;
        logic                  pslverr;
        logic                  tx_hi;
        logic                  tx_lo;
        logic                  rx_hi;
        logic                  rx_lo;
        logic                  rx_valid;
        logic                  oe_pos;
    } dio_state_t;

    typedef struct packed {
        logic fall_q;
        logic oe_neg;
    } dio_neg_t;

    localparam dio_state_t ST_RST = '{
        mode:     DIO_MODE_RST,
        tri_low:  DIO_TRI_LOW_RST,
        oce_use:  DIO_OCE_USE_RST,
        no_dqs:   DIO_NO_DQS_RST,
        sclr_bit: DIO_SCLR_RST,
        prdata:   '0,
        pslverr:  1'h0,
        tx_hi:    PWR_UP_HIGH,
        tx_lo:    PWR_UP_HIGH,
        rx_hi:    PWR_UP_HIGH,
        rx_lo:    PWR_UP_HIGH,
        rx_valid: 1'h0,
        oe_pos:   1'h0
    };

    localparam dio_neg_t NEG_RST = '{fall_q: PWR_UP_HIGH, oe_neg: 1'h0};

    dio_state_t state_r;
    dio_state_t state_nxt;
    dio_neg_t   neg_r;
    dio_neg_t   neg_nxt;
    logic       fall_hold;
    logic       sync_clr;
    logic       drive_req;
    logic       ce_eff;
    logic       is_in;
    logic       is_out;
    logic       is_bidir;

    function automatic logic mapped(input logic [DIO_ADDR_W-1:0] a);
        mapped = (a == DIO_CTRL_OFS) || (a == DIO_STAT_OFS);
    endfunction

    always_comb begin
        is_in    = (state_r.mode == DIO_MODE_IN);
        is_out   = (state_r.mode == DIO_MODE_OUT);
        is_bidir = (state_r.mode == DIO_MODE_BIDIR);
    end

    assign sync_clr  = sclr | state_r.sclr_bit;
    assign drive_req = state_r.tri_low ? ~oe_req : oe_req;
    // clock enable only matters when software opts into it
    assign ce_eff    = ~state_r.oce_use | ce_out;

    // transparent while the clock is low, holds the falling-edge bit while high
    always_latch begin
        if (!pclk) begin
            fall_hold = neg_r.fall_q;
        end
    end

    always_comb begin
        neg_nxt        = neg_r;
        neg_nxt.fall_q = dq_i;
        // holding the enable to the falling edge keeps the driver off the
        // bus for the first half cycle after a read turnaround
        neg_nxt.oe_neg = is_bidir & drive_req;
        if (sync_clr) begin
            neg_nxt = NEG_RST;
        end
    end

    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_r <= NEG_RST;
        end else begin
            neg_r <= neg_nxt;
        end
    end

    always_comb begin
        state_nxt         = state_r;
        state_nxt.pslverr = 1'h0;
        // register bus: answer prepared in the setup phase, no wait states
        if (psel && !penable) begin
            state_nxt.prdata  = '0;
            state_nxt.pslverr = ~mapped(paddr);
            if (!pwrite && paddr == DIO_CTRL_OFS) begin
                state_nxt.prdata[DIO_CTRL_MODE_LSB +: 2] = state_r.mode;
                state_nxt.prdata[DIO_CTRL_TRI_LOW]       = state_r.tri_low;
                state_nxt.prdata[DIO_CTRL_OCE_USE]       = state_r.oce_use;
                state_nxt.prdata[DIO_CTRL_NO_DQS]        = state_r.no_dqs;
                state_nxt.prdata[DIO_CTRL_SCLR]          = state_r.sclr_bit;
            end else if (!pwrite && paddr == DIO_STAT_OFS) begin
                state_nxt.prdata[DIO_STAT_RX_LO]         = state_r.rx_lo;
                state_nxt.prdata[DIO_STAT_RX_HI]         = state_r.rx_hi;
                state_nxt.prdata[DIO_STAT_RX_VALID]      = state_r.rx_valid;
                state_nxt.prdata[DIO_STAT_DRIVE]         = ~dq_oe_n;
                state_nxt.prdata[DIO_STAT_MODE_LSB +: 2] = state_r.mode;
            end
        end else if (psel && penable) begin
            state_nxt.pslverr = state_r.pslverr;
        end
        if (psel && penable && pwrite && paddr == DIO_CTRL_OFS && pstrb[0]) begin
            state_nxt.mode     = pwdata[DIO_CTRL_MODE_LSB +: 2];
            state_nxt.tri_low  = pwdata[DIO_CTRL_TRI_LOW];
            state_nxt.oce_use  = pwdata[DIO_CTRL_OCE_USE];
            state_nxt.no_dqs   = pwdata[DIO_CTRL_NO_DQS];
            state_nxt.sclr_bit = pwdata[DIO_CTRL_SCLR];
        end

        // capture path, used by input and bidirectional modes
        if (is_in || is_bidir) begin
            state_nxt.rx_lo    = dq_i;
            state_nxt.rx_hi    = fall_hold;
            // without strobe support the clock alone qualifies the data
            state_nxt.rx_valid = state_r.no_dqs | dqs_i;
        end else begin
            state_nxt.rx_valid = 1'h0;
        end

        // launch path; retains data whenever the clock enable is low
        if ((is_out || is_bidir) && ce_eff) begin
            state_nxt.tx_hi = tx_hi;
            state_nxt.tx_lo = tx_lo;
        end
        state_nxt.oe_pos = is_out & drive_req;

        if (sync_clr) begin
            state_nxt.tx_hi    = PWR_UP_HIGH;
            state_nxt.tx_lo    = PWR_UP_HIGH;
            state_nxt.rx_hi    = PWR_UP_HIGH;
            state_nxt.rx_lo    = PWR_UP_HIGH;
            state_nxt.rx_valid = 1'h0;
            state_nxt.oe_pos   = 1'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // glitch-free only if the two registers settle before the clock level flips
    assign dq_o     = pclk ? state_r.tx_hi : state_r.tx_lo;
    assign dq_oe_n  = ~(state_r.oe_pos | neg_r.oe_neg);
    assign prdata   = state_r.prdata;
    assign pready   = 1'h1;
    assign pslverr  = state_r.pslverr & psel & penable;
    assign rx_hi    = state_r.rx_hi;
    assign rx_lo    = state_r.rx_lo;
    assign rx_valid = state_r.rx_valid;

    sequence bidir_req_s;
        is_bidir && drive_req && !sync_clr;
    endsequence

    sequence oe_on_s;
        !dq_oe_n;
    endsequence

    // a capture cycle: a mode with an input path and no clear pending
    sequence capture_s;
        (is_in || is_bidir) && !sync_clr;
    endsequence

    oe_reset_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> dq_oe_n)
        else $error("output enable active right after reset");

    rise_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        (is_in && !sync_clr) ##1 is_in |-> rx_lo == $past(dq_i))
        else $error("rising-edge capture lost pin value");

    hi_align_a: assert property (@(negedge pclk) disable iff (!presetn)
        (is_bidir && !sync_clr) ##1 (is_bidir && !sync_clr) |=> rx_hi == $past(dq_i))
        else $error("falling-edge bit not aligned to rising edge");

    pin_hi_a: assert property (@(negedge pclk) disable iff (!presetn)
        dq_o == state_r.tx_hi)
        else $error("first bit not on pin during clock high");

    pin_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
        dq_o == state_r.tx_lo)
        else $error("second bit not on pin during clock low");

    tx_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((is_out || is_bidir) && ce_eff && !sync_clr)
        |=> (state_r.tx_hi == $past(tx_hi)) && (state_r.tx_lo == $past(tx_lo)))
        else $error("output registers did not load");

    tx_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r.oce_use && !ce_out && !sync_clr)
        |=> $stable(state_r.tx_hi) && $stable(state_r.tx_lo))
        else $error("output registers changed with clock enable low");

    bidir_oe_a: assert property (@(negedge pclk) disable iff (!presetn)
        bidir_req_s |=> oe_on_s)
        else $error("bidir driver not enabled at falling edge");

    bidir_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_bidir ##1 is_bidir |-> !state_r.oe_pos)
        else $error("bidir enable driven by the rising-edge register");

    tri_pol_a: assert property (@(negedge pclk) disable iff (!presetn)
        (is_bidir && state_r.tri_low && oe_req && !state_r.oe_pos) |=> dq_oe_n)
        else $error("active-low tristate polarity ignored");

    no_dqs_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((is_in || is_bidir) && state_r.no_dqs && !sync_clr) |=> rx_valid)
        else $error("strobe not ignored in clock capture mode");

    strobe_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
        (capture_s and !state_r.no_dqs) |=> rx_valid == $past(dqs_i))
        else $error("strobe qualifier not carried into valid flag");

    latch_align_a: assert property (@(posedge pclk) disable iff (!presetn)
        capture_s |=> rx_hi == $past(neg_r.fall_q))
        else $error("latched falling-edge bit not presented at rising edge");

    // output mode freezes the capture path and clears its valid flag
    out_no_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_out |=> !rx_valid)
        else $error("valid flag raised in output mode");

    out_rx_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (is_out && !sync_clr) |=> $stable(rx_lo) && $stable(rx_hi))
        else $error("capture registers moved in output mode");

    // input mode must neither load the launch registers nor drive the pin
    in_tx_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (is_in && !sync_clr) |=> $stable(state_r.tx_hi) && $stable(state_r.tx_lo))
        else $error("output registers loaded in input mode");

    in_no_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_in ##1 is_in |-> dq_oe_n)
        else $error("pin driven in input mode");

    out_oe_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        (is_out && !sync_clr) |=> state_r.oe_pos == $past(drive_req))
        else $error("output-mode enable did not follow the request");

    neg_oe_idle_a: assert property (@(negedge pclk) disable iff (!presetn)
        !is_bidir |=> !neg_r.oe_neg)
        else $error("falling-edge enable set outside bidir mode");

    // the clear reaches the two enable registers on their own edges
    sclr_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
        sync_clr |=> !state_r.oe_pos && !rx_valid)
        else $error("sync reset left rising-edge enable or valid set");

    sclr_neg_a: assert property (@(negedge pclk) disable iff (!presetn)
        sync_clr |=> !neg_r.oe_neg)
        else $error("sync reset left falling-edge enable set");

    reset_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> !rx_valid && (state_r.tx_hi == PWR_UP_HIGH))
        else $error("registers not at power-up level after reset");

    sclr_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        sclr |=> (state_r.tx_hi == PWR_UP_HIGH) && dq_oe_n ##1 dq_oe_n || !sclr)
        else $error("sync reset did not restore power-up level");

endmodule

`default_nettype wire

// *** bench/dio_mem_model.sv ***
// Purpose: memory-side model that drives the shared data pin and read strobe
// Assumes: data change by non-blocking update right at each clock edge
// Notes:   a released pin toggles every half cycle so stale data never match
`timescale 1ns/1ps
`default_nettype none
module dio_mem_model (
    input  wire logic pclk,
    input  wire logic drive,
    input  wire logic d_hi,
    input  wire logic d_lo,
    output logic      dq,
    output logic      dqs
);
    logic lo_q;
    logic drv_q;
    initial begin
        dq = 1'h0;
        dqs = 1'h0;
        lo_q = 1'h0;
        drv_q = 1'h0;
    end
    // high-phase bit launched at the rising edge, low-phase bit at the falling edge;
    // the low bit and the drive flag are kept from the same rising edge so a pair
    // never mixes two requests
    always @(posedge pclk) begin
        dq <= drive ? d_hi : ~dq;
        dqs <= drive;
        lo_q <= d_lo;
        drv_q <= drive;
    end
    always @(negedge pclk) begin
        dq <= drv_q ? lo_q : ~dq;
    end
endmodule
`default_nettype wire

// *** bench/ddr_io_element_tb.sv ***
// Purpose: self-checking bench for the double-data-rate pin cell
// Assumes: apb master waits for pready under a bounded count
// Notes:   inputs move by non-blocking assignment at rising edges only
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module ddr_io_element_tb;
    import dio_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, rx_hi, rx_lo, rx_valid, dq_i, dq_o, dq_oe_n, dqs_i;
    logic        tx_hi = 1'h0, tx_lo = 1'h0, ce_out = 1'h1, oe_req = 1'h0, sclr = 1'h0;
    logic        m_drv = 1'h0, m_hi = 1'h0, m_lo = 1'h0, m_dq;
    int          fail_count = 0, n_compared = 0;

    always #5 pclk = ~pclk;
    // pin level: the cell wins while its enable is low, else the memory drives
    assign dq_i = dq_oe_n ? m_dq : dq_o;

    dio_io_cell dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
        .prdata, .pready, .pslverr, .tx_hi, .tx_lo, .ce_out, .oe_req, .sclr,
        .rx_hi, .rx_lo, .rx_valid, .dq_i, .dq_o, .dq_oe_n, .dqs_i
    );
    dio_mem_model mem (.pclk(pclk), .drive(m_drv), .d_hi(m_hi), .d_lo(m_lo),
                       .dq(m_dq), .dqs(dqs_i));

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            $display("MISMATCH t=%0t bus answer timed out", $time);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 32'h0, r, e);
        `CHK(r, x)
        `CHK(e, xe)
    endtask
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        fail_count++;
        stop_test();
    end

    initial begin
        int k;
        repeat (3) @(posedge pclk);
        `CHK(dq_oe_n, 1'h1)
        presetn <= 1'h1;
        rd(DIO_CTRL_OFS, 32'h2, 1'h0);
        rd(8'h08, 32'h0, 1'h1);
        wr(DIO_STAT_OFS, 32'hFF);
        rd(DIO_CTRL_OFS, 32'h2, 1'h0);
        // capture in bidir mode with the cell released, two-cycle pipeline
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            m_drv <= 1'h1;
            m_hi <= i[0];
            m_lo <= i[1];
            #1;
            k = i - 2;
            if (i >= 3) begin
                `CHK(rx_hi, k[0])
                `CHK(rx_lo, k[1])
                `CHK(rx_valid, 1'h1)
            end
        end
        @(posedge pclk);
        m_drv <= 1'h0;
        wr(DIO_CTRL_OFS, 32'h12);
        repeat (2) @(posedge pclk);
        #1 `CHK(rx_valid, 1'h1)
        wr(DIO_CTRL_OFS, 32'h2);
        repeat (2) @(posedge pclk);
        #1 `CHK(rx_valid, 1'h0)
        // synchronous clear in input mode
        wr(DIO_CTRL_OFS, 32'h0);
        m_drv <= 1'h1;
        m_hi <= 1'h1;
        m_lo <= 1'h1;
        repeat (4) @(posedge pclk);
        #1 `CHK(rx_lo, 1'h1)
        @(posedge pclk);
        sclr <= 1'h1;
        @(posedge pclk);
        #1 `CHK(rx_lo, 1'h0)
        `CHK(rx_valid, 1'h0)
        @(posedge pclk);
        sclr <= 1'h0;
        m_drv <= 1'h0;
        // launch in output mode, back-to-back pairs
        wr(DIO_CTRL_OFS, 32'h1);
        oe_req <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            tx_hi <= i[0];
            tx_lo <= i[1];
            k = i - 1;
            if (i > 1) begin
                #2 `CHK(dq_o, k[0])
                #5 `CHK(dq_o, k[1])
                `CHK(dq_oe_n, 1'h0)
            end
        end
        wr(DIO_CTRL_OFS, 32'h9);
        ce_out <= 1'h0;
        tx_hi <= 1'h0;
        tx_lo <= 1'h0;
        repeat (2) @(posedge pclk);
        #2 `CHK(dq_o, 1'h1)
        @(posedge pclk);
        ce_out <= 1'h1;
        @(posedge pclk);
        #2 `CHK(dq_o, 1'h0)
        // active-low tristate: a high request now means released
        wr(DIO_CTRL_OFS, 32'h5);
        @(posedge pclk);
        #1 `CHK(dq_oe_n, 1'h1)
        @(posedge pclk);
        oe_req <= 1'h0;
        @(posedge pclk);
        #1 `CHK(dq_oe_n, 1'h0)
        // bidir enable waits for the falling edge
        wr(DIO_CTRL_OFS, 32'h2);
        @(posedge pclk);
        #1 `CHK(dq_oe_n, 1'h1)
        @(posedge pclk);
        oe_req <= 1'h1;
        #1 `CHK(dq_oe_n, 1'h1)
        @(negedge pclk);
        #1 `CHK(dq_oe_n, 1'h0)
        // active-low tristate in bidir mode: a high request releases the pin
        wr(DIO_CTRL_OFS, 32'h6);
        @(posedge pclk);
        #1 `CHK(dq_oe_n, 1'h1)
        @(posedge pclk);
        presetn <= 1'h0;
        @(posedge pclk);
        #1 `CHK(dq_oe_n, 1'h1)
        stop_test();
    end
endmodule
`default_nettype wire
